// File: verilog/spm_cfg.svh
// named constants of the self-programming control block
// assumes one 250 MHz clock and a word-wide AHB-Lite register port
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// ===========================================================
// register map
`define SPMC_INDEX      8'h37
`define SPMC_ADDR       10'h0dc
`define SPMC_RESET      8'h00
`define ADDR_W          10
// ===========================================================
// control/status field positions
`define BIT_IRQ_EN      7
`define BIT_RWW_BUSY    6
`define BIT_RESERVED    5
`define BIT_RWW_REEN    4
`define BIT_LOCK_SEL    3
`define BIT_PAGE_WRITE  2
`define BIT_PAGE_ERASE  1
`define BIT_SELF_EN     0
// ===========================================================
// accepted lower-five-bit command patterns
`define PAT_RWW_REEN    5'b10001
`define PAT_LOCK_READ   5'b01001
`define PAT_PAGE_WRITE  5'b00101
`define PAT_PAGE_ERASE  5'b00011
`define PAT_BUF_FILL    5'b00001
// ===========================================================
// arming windows in cpu cycles
`define SPM_WINDOW      3'h4
`define LPM_WINDOW      3'h3
// ===========================================================
// readback selectors
`define Z_LOCK          16'h0001
`define Z_FUSE_LOW      16'h0000
`define Z_FUSE_HIGH     16'h0003
`define Z_FUSE_EXT      16'h0002
// lock byte: app section write-protect bit, boot section write-protect bit
`define LOCK_APP_WP     2
`define LOCK_BOOT_WP    4
`endif

// File: verilog/spm_pkg.sv
// types shared by the self-programming control block
// assumes the constants header is included by its users
package spm_pkg;
    // ===========================================================
    // armed command
    typedef enum logic [2:0] {
        CMD_NONE  = 3'b000,
        CMD_FILL  = 3'b001,
        CMD_ERASE = 3'b010,
        CMD_WRITE = 3'b011,
        CMD_RWW   = 3'b100,
        CMD_LOCK  = 3'b101
    } cmd_t;
    // flash array operation kind
    typedef enum logic [0:0] {
        OP_ERASE = 1'b0,
        OP_WRITE = 1'b1
    } flash_op_t;
endpackage

// File: verilog/self_programming_control.sv
// self-programming control/status register with its arming windows
// assumes the cpu core reports spm/lpm execution and the flash array
// reports completion of an erase or write with a one-cycle done pulse
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "spm_cfg.svh"

// Contract
// - irq when enable, global ie, self-prog clear
// - irq suppressed during eeprom write or spm
// - rww busy reads zero on small variant
// - bit five reserved, reads zero
// - rww re-enable during fill clears buffer
// - lpm within three cycles returns lock/fuse
// - armed page write writes buffer to page
// - page write bit clears at done/timeout
// - cpu halted during page write
// - armed page erase erases addressed page
// - page erase bit clears at done/timeout
// - self-prog enable opens four-cycle spm window
// - plain enable stores word into buffer
// - self-prog enable clears after spm/timeout
// - enable held high during erase/write
// - only listed five-bit patterns take effect
// - spm from application section is disabled
// - spm from boot section reaches whole flash
// - sections protected by separate lock bits
// - rww busy high while rww section blocked
// - z selects lock, fuse low/high/ext
// - programmed bits read zero, unprogrammed one
module self_programming_control #(
    parameter bit RWW_SUPPORTED = 1'b1,   // 0 models the smallest variant
    parameter int PAGE_BITS     = 7,      // byte-address bits inside a page
    parameter int FLASH_WORDS   = 16384,  // flash size in 16-bit words
    parameter int BOOT_MIN      = 256,    // boot section words at size fuses 11
    parameter int NRWW_START    = 14336   // first word of the no-rww section
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // cpu core side
    input  wire logic                 global_irq_enable,
    input  wire logic                 eeprom_busy,
    input  wire logic                 spm_exec,
    input  wire logic                 lpm_exec,
    input  wire logic                 exec_from_boot,
    input  wire logic [15:0]          z_pointer,
    input  wire logic [15:0]          r1_r0_word,
    output logic                      prog_ready_irq,
    output logic                      cpu_halt,
    output logic                      lpm_override,
    output logic      [7:0]           lpm_data,
    // fuses and lock bits, programmed bits at zero
    input  wire logic [1:0]           boot_size_fuses,
    input  wire logic [7:0]           lock_bits,
    input  wire logic [7:0]           fuse_low,
    input  wire logic [7:0]           fuse_high,
    input  wire logic [7:0]           fuse_ext,
    // flash array and temporary page buffer
    output logic                      buf_wr,
    output logic      [PAGE_BITS-2:0] buf_word,
    output logic      [15:0]          buf_data,
    output logic                      buf_clear,
    output logic                      flash_start,
    output spm_pkg::flash_op_t        flash_op,
    output logic      [15:0]          flash_addr,
    input  wire logic                 flash_done
);
    import spm_pkg::*;

    // ===========================================================
    // helpers

    // lower five register bits for an armed command
    function automatic logic [4:0] cmd_bits(input cmd_t c);
        case (c)
            CMD_FILL:  cmd_bits = `PAT_BUF_FILL;
            CMD_ERASE: cmd_bits = `PAT_PAGE_ERASE;
            CMD_WRITE: cmd_bits = `PAT_PAGE_WRITE;
            CMD_RWW:   cmd_bits = `PAT_RWW_REEN;
            CMD_LOCK:  cmd_bits = `PAT_LOCK_READ;
            default:   cmd_bits = 5'h00;
        endcase
    endfunction

    // written pattern to command; anything unlisted maps to none
    function automatic cmd_t decode(input logic [4:0] p);
        case (p)
            `PAT_BUF_FILL:   decode = CMD_FILL;
            `PAT_PAGE_ERASE: decode = CMD_ERASE;
            `PAT_PAGE_WRITE: decode = CMD_WRITE;
            `PAT_RWW_REEN:   decode = CMD_RWW;
            `PAT_LOCK_READ:  decode = CMD_LOCK;
            default:         decode = CMD_NONE;
        endcase
    endfunction

    // ===========================================================
    // state

    logic        irq_enable;    // stored interrupt enable bit
    cmd_t        armed;         // command waiting for spm or lpm
    logic [2:0]  window;        // cycles left in the arming window
    logic        op_busy;       // flash erase or write in progress
    logic        rww_busy;      // rww section blocked for reading
    logic        buf_dirty;     // page buffer holds filled words
    logic        wr_pend;       // write data phase pending
    logic        rd_wait;       // read wait state
    logic        addr_hit;      // data phase targets the register
    logic [7:0]  reg_value;     // register as software reads it
    logic        take;          // address phase accepted
    logic        wr_now;        // write data taken this cycle
    cmd_t        next_cmd;      // decoded written command
    logic        cmd_ok;        // written command takes effect
    logic        spm_ok;        // spm may act this cycle
    logic        lpm_ok;        // lpm readback this cycle
    logic [14:0] boot_start;    // first word of boot section
    logic        tgt_boot;      // z targets boot section
    logic        tgt_locked;    // target section write-protected

    // ===========================================================
    // combinational decode

    assign take   = hsel && hready && htrans[1];
    assign wr_now = wr_pend;
    // busy flash or eeprom write block new commands; the enable bit
    // therefore stays high until the operation ends
    assign next_cmd = decode(hwdata[4:0]);
    assign cmd_ok   = wr_now && addr_hit && !op_busy && !eeprom_busy
                      && (next_cmd != CMD_NONE);
    // only boot code may program, but it may target any address
    assign spm_ok = spm_exec && exec_from_boot && (window != 3'h0)
                    && !op_busy;
    assign lpm_ok = lpm_exec && (armed == CMD_LOCK)
                    && (window > (`SPM_WINDOW - `LPM_WINDOW));

    // boot boundary from the size fuses, smallest at 11
    assign boot_start = 15'(FLASH_WORDS - (BOOT_MIN << (2'd3 - boot_size_fuses)));
    assign tgt_boot   = (z_pointer[15:1] >= boot_start);
    // each section has its own write-protect lock bit, 0 = programmed
    assign tgt_locked = tgt_boot ? !lock_bits[`LOCK_BOOT_WP]
                                 : !lock_bits[`LOCK_APP_WP];

    // software view: bit 5 always zero, bit 6 zero on small variant
    always_comb begin
        reg_value                  = `SPMC_RESET;
        reg_value[`BIT_IRQ_EN]     = irq_enable;
        reg_value[`BIT_RWW_BUSY]   = RWW_SUPPORTED && rww_busy;
        reg_value[`BIT_RESERVED]   = 1'b0;
        reg_value[4:0]             = cmd_bits(armed);
    end

    // ===========================================================
    // ahb-lite slave: writes zero-wait, reads one wait state

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend  <= 1'b0;
            rd_wait  <= 1'b0;
            addr_hit <= 1'b0;
        end else if (hreadyout) begin
            wr_pend  <= take && hwrite;
            rd_wait  <= take && !hwrite;
            addr_hit <= (haddr[`ADDR_W-1:0] == `SPMC_ADDR) && (haddr[31:`ADDR_W] == '0);
        end else begin
            rd_wait  <= 1'b0;
        end
    end

    // read data loaded in the wait state so a prior write is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            hrdata <= addr_hit ? {24'h00_0000, reg_value} : 32'h0000_0000;
        end
    end

    assign hreadyout = !rd_wait;
    assign hresp     = 1'b0;   // always okay, unmapped reads zero

    // ===========================================================
    // interrupt enable bit, written by any register write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable <= 1'b0;
        end else if (wr_now && addr_hit) begin
            irq_enable <= hwdata[`BIT_IRQ_EN];
        end
    end

    // level request while the enable bit is clear and nothing writes
    assign prog_ready_irq = irq_enable && global_irq_enable
                            && (armed == CMD_NONE)
                            && !eeprom_busy && !op_busy;

    // ===========================================================
    // command arming, window count and consumption
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed  <= CMD_NONE;
            window <= 3'h0;
        end else if (op_busy) begin
            // enable and op bit stay set until the array reports done
            if (flash_done) begin
                armed <= CMD_NONE;
            end
        end else if (cmd_ok) begin
            armed  <= next_cmd;
            window <= `SPM_WINDOW;
        end else if (lpm_ok) begin
            armed  <= CMD_NONE;
            window <= 3'h0;
        end else if (spm_ok) begin
            // erase/write keep their bits for the whole operation
            if (!((armed == CMD_ERASE || armed == CMD_WRITE) && !tgt_locked)) begin
                armed <= CMD_NONE;
            end
            window <= 3'h0;
        end else if (window != 3'h0) begin
            window <= window - 3'h1;
            if (window == 3'h1) begin
                armed <= CMD_NONE;
            end
        end
    end

    // ===========================================================
    // flash operation start and completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_busy     <= 1'b0;
            flash_start <= 1'b0;
            flash_op    <= OP_ERASE;
            flash_addr  <= 16'h0000;
        end else begin
            flash_start <= 1'b0;
            if (op_busy && flash_done) begin
                op_busy <= 1'b0;
            end else if (spm_ok && !tgt_locked && armed == CMD_ERASE) begin
                op_busy     <= 1'b1;
                flash_start <= 1'b1;
                flash_op    <= OP_ERASE;
                flash_addr  <= {z_pointer[15:PAGE_BITS], PAGE_BITS'(0)};
            end else if (spm_ok && !tgt_locked && armed == CMD_WRITE) begin
                op_busy     <= 1'b1;
                flash_start <= 1'b1;
                flash_op    <= OP_WRITE;
                flash_addr  <= {z_pointer[15:PAGE_BITS], PAGE_BITS'(0)};
            end
        end
    end

    // the core stalls for the whole erase or write
    assign cpu_halt = op_busy;

    // ===========================================================
    // read-while-write section blocking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rww_busy <= 1'b0;
        end else if (flash_start && (flash_addr[15:1] < 15'(NRWW_START))) begin
            rww_busy <= 1'b1;
        end else if (spm_ok && armed == CMD_RWW) begin
            rww_busy <= 1'b0;
        end
    end

    // ===========================================================
    // temporary page buffer fill and clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_wr    <= 1'b0;
            buf_clear <= 1'b0;
            buf_word  <= '0;
            buf_data  <= 16'h0000;
            buf_dirty <= 1'b0;
        end else begin
            buf_wr    <= 1'b0;
            buf_clear <= 1'b0;
            if (spm_ok && armed == CMD_FILL) begin
                // byte-address lsb ignored: one word per location
                buf_wr    <= 1'b1;
                buf_word  <= z_pointer[PAGE_BITS-1:1];
                buf_data  <= r1_r0_word;
                buf_dirty <= 1'b1;
            end else if (cmd_ok && next_cmd == CMD_RWW && buf_dirty) begin
                buf_clear <= 1'b1;
                buf_dirty <= 1'b0;
            end else if (op_busy && flash_done && flash_op == OP_WRITE) begin
                buf_dirty <= 1'b0;
            end
        end
    end

    // ===========================================================
    // lock and fuse readback, one-cycle override of the lpm result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lpm_override <= 1'b0;
            lpm_data     <= 8'h00;
        end else begin
            lpm_override <= lpm_ok;
            if (lpm_ok) begin
                // values pass as stored: programmed bits already zero
                case (z_pointer)
                    `Z_LOCK:      lpm_data <= lock_bits;
                    `Z_FUSE_LOW:  lpm_data <= fuse_low;
                    `Z_FUSE_HIGH: lpm_data <= fuse_high;
                    `Z_FUSE_EXT:  lpm_data <= fuse_ext;
                    default:      lpm_data <= 8'hff;
                endcase
            end
        end
    end

    // ===========================================================
    // checks

    chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        prog_ready_irq |-> !eeprom_busy && !op_busy && irq_enable)
        else $error("ready irq raised while busy or disabled");

    chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        !reg_value[`BIT_RESERVED] && (RWW_SUPPORTED || !reg_value[`BIT_RWW_BUSY]))
        else $error("reserved or small-variant busy bit read as one");

    chk_window_expiry: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmd_ok && !eeprom_busy) ##1 (!spm_exec && !lpm_exec && !op_busy)[*4]
        |=> armed == CMD_NONE)
        else $error("armed command survived its window");

    chk_armed_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_ok ##1 (!spm_exec && !lpm_exec && !wr_pend)[*3] |-> armed != CMD_NONE)
        else $error("armed command cleared early");

    // bounded form: every cycle of a running operation without done keeps the halt
    chk_halt_op: assert property (@(posedge hclk) disable iff (!hresetn)
        (flash_start || (op_busy && !flash_done)) |-> cpu_halt ##1 cpu_halt)
        else $error("core not halted during flash operation");

    chk_enable_held: assert property (@(posedge hclk) disable iff (!hresetn)
        op_busy |-> reg_value[`BIT_SELF_EN])
        else $error("enable bit dropped during flash operation");

    chk_app_no_spm: assert property (@(posedge hclk) disable iff (!hresetn)
        (spm_exec && !exec_from_boot) |=> !flash_start && !buf_wr)
        else $error("spm from application section acted");

    chk_bad_pattern: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && addr_hit && decode(hwdata[4:0]) == CMD_NONE && !spm_exec && !lpm_exec)
        |=> $stable(armed) || armed == CMD_NONE)
        else $error("unlisted pattern changed the armed command");

    chk_lpm_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (lpm_ok && z_pointer == `Z_LOCK) |=> lpm_override && lpm_data == $past(lock_bits))
        else $error("lock readback wrong");

    chk_fill_word: assert property (@(posedge hclk) disable iff (!hresetn)
        (spm_ok && armed == CMD_FILL) |=> buf_wr && buf_data == $past(r1_r0_word))
        else $error("buffer fill word wrong");

endmodule // self_programming_control

// File: verification/flash_array_model.sv
// behavioural flash array: answers each start with a one-cycle done
// assumes the controller raises flash_start for one cycle per operation
`timescale 1ns/1ns
module flash_array_model #(
    parameter int BUSY_CYCLES = 20  // erase/write time, shortened for the run
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // controller side
    input  wire logic flash_start,
    output logic      flash_done
);
    int cnt;  // cycles left in the running operation
    // ===========================================================
    // operation timer; done is low outside its single cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt        <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (flash_start) begin
                cnt <= BUSY_CYCLES;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // flash_array_model

// File: verification/self_programming_control_test.sv
// self-checking bench: ahb-lite master, cpu pulses, flash model
// assumes default design parameters and the constants header
`timescale 1ns/1ns
`include "spm_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module self_programming_control_test;
    import spm_pkg::*;
    // ===========================================================
    // bench signals
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic        gie, ee_busy, spm_exec, lpm_exec, from_boot;
    logic [15:0] z_pointer, r1_r0_word, flash_addr, buf_data;
    logic        irq, cpu_halt, lpm_override, buf_wr, buf_clear, flash_start, flash_done;
    logic [7:0]  lpm_data, rdv, lock_bits;
    logic [5:0]  buf_word;
    flash_op_t   flash_op;
    int          err_count, n_checks;
    localparam logic [31:0] A = {22'h0, `SPMC_ADDR};  // register byte address
    self_programming_control i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .global_irq_enable(gie), .eeprom_busy(ee_busy), .spm_exec(spm_exec),
        .lpm_exec(lpm_exec), .exec_from_boot(from_boot), .z_pointer(z_pointer),
        .r1_r0_word(r1_r0_word), .prog_ready_irq(irq), .cpu_halt(cpu_halt),
        .lpm_override(lpm_override), .lpm_data(lpm_data), .boot_size_fuses(2'h3),
        .lock_bits(lock_bits), .fuse_low(8'h62), .fuse_high(8'hd9), .fuse_ext(8'hfd),
        .buf_wr(buf_wr), .buf_word(buf_word), .buf_data(buf_data), .buf_clear(buf_clear),
        .flash_start(flash_start), .flash_op(flash_op), .flash_addr(flash_addr),
        .flash_done(flash_done));
    flash_array_model i_flash (.hclk(hclk), .hresetn(hresetn),
        .flash_start(flash_start), .flash_done(flash_done));
    // ===========================================================
    // clock and bus tasks
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task close_out;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // settled hready is judged before the edge that ends the phase
    task wt;
        int i;
        i = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && i < 50) begin
            @(negedge hclk);
            i++;
        end
        if (i >= 50) err_count++;
        if (i >= 50) close_out();
        rdv = hrdata[7:0];
        @(posedge hclk);
    endtask
    task xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
        // start on a rising edge so the address phase is sampled only once
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wt();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wt();
    endtask
    // spm strobe in the first window cycle after a write
    task sp(input logic [15:0] z, input logic boot);
        spm_exec <= 1'b1;
        z_pointer <= z;
        from_boot <= boot;
        @(posedge hclk);
        spm_exec <= 1'b0;
        @(negedge hclk);
    endtask
    // waits for the flash model to finish; a hang ends the run
    task wait_idle;
        int i;
        i = 0;
        @(negedge hclk);
        while (cpu_halt !== 1'b0 && i < 100) begin
            @(negedge hclk);
            i++;
        end
        `CHK(i < 100, 1'b1)
        if (i >= 100) close_out();
    endtask
    // ===========================================================
    // scenarios
    task t_regs;
        xfer(A, 1'b0, 8'h00); `CHK(rdv, `SPMC_RESET)
        xfer(A + 4, 1'b0, 8'h00); `CHK(rdv, 8'h00)
        xfer(A, 1'b1, 8'he7);
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h80)
        gie <= 1'b1; @(negedge hclk); `CHK(irq, 1'b1)
        @(posedge hclk); ee_busy <= 1'b1; @(negedge hclk); `CHK(irq, 1'b0)
        @(posedge hclk); ee_busy <= 1'b0; gie <= 1'b0; xfer(A, 1'b1, 8'h00);
    endtask
    task t_fill;
        r1_r0_word <= 16'hbeef;
        xfer(A, 1'b1, 8'h01); sp(16'h0013, 1'b1);
        `CHK(buf_wr, 1'b1)
        `CHK({buf_word, buf_data}, {6'h09, 16'hbeef})
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
        xfer(A, 1'b1, 8'h11); @(negedge hclk); `CHK(buf_clear, 1'b1)
        repeat (6) @(posedge hclk);
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
    endtask
    task t_op(input logic [7:0] cmd, input flash_op_t k);
        xfer(A, 1'b1, cmd); sp(16'h7f80, 1'b1);
        `CHK({flash_start, flash_op}, {1'b1, k})
        `CHK(flash_addr, 16'h7f80)
        @(negedge hclk); `CHK(cpu_halt, 1'b1)
        xfer(A, 1'b0, 8'h00); `CHK(rdv, cmd)
        wait_idle();
        @(posedge hclk); xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
    endtask
    // erase inside the rww section blocks it until a re-enable spm
    task t_rww;
        xfer(A, 1'b1, 8'h03); sp(16'h0100, 1'b1);
        `CHK(flash_addr, 16'h0100)
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h43)
        wait_idle();
        @(posedge hclk); xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h40)
        xfer(A, 1'b1, 8'h11); sp(16'h0000, 1'b1);
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
    endtask
    task t_app;
        xfer(A, 1'b1, 8'h05); sp(16'h7f80, 1'b0); `CHK(flash_start, 1'b0)
        repeat (5) @(posedge hclk);
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
    endtask
    // each section refused by its own write-protect lock bit
    task t_prot;
        lock_bits <= 8'h3b;
        xfer(A, 1'b1, 8'h03); sp(16'h0100, 1'b1); `CHK(flash_start, 1'b0)
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
        lock_bits <= 8'h2f;
        xfer(A, 1'b1, 8'h05); sp(16'h7f80, 1'b1); `CHK(flash_start, 1'b0)
        xfer(A, 1'b0, 8'h00); `CHK(rdv, 8'h00)
        lock_bits <= 8'h3f;
    endtask
    task t_lock;
        logic [7:0] ex [4];
        ex = '{8'h62, 8'h3f, 8'hfd, 8'hd9};
        for (int i = 0; i < 4; i++) begin
            xfer(A, 1'b1, 8'h09);
            lpm_exec <= 1'b1;
            z_pointer <= i[15:0];
            @(posedge hclk);
            lpm_exec <= 1'b0;
            @(negedge hclk);
            `CHK({lpm_override, lpm_data}, {1'b1, ex[i]})
            @(posedge hclk);
        end
    endtask
    // ===========================================================
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, gie, ee_busy, spm_exec, lpm_exec, from_boot} = '0;
        {haddr, hwdata, htrans, z_pointer, r1_r0_word, err_count, n_checks} = '0;
        lock_bits = 8'h3f;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs(); t_fill(); t_op(8'h03, OP_ERASE); t_op(8'h05, OP_WRITE);
        t_rww(); t_app(); t_prot(); t_lock();
        close_out();
    end
endmodule // self_programming_control_test
